// *** design/tsl_defs.vh ***
`ifndef TSL_DEFS_VH
`define TSL_DEFS_VH
// Register indices; byte address is four times the index
`define TSL_CTRL_IDX 10'h170
`define TSL_RXCODE_IDX 10'h171
`define TSL_EXP1_IDX 10'h172
`define TSL_EXP2_IDX 10'h173
`define TSL_EXP3_IDX 10'h174
`define TSL_TXCODE_IDX 10'h175
`define TSL_REPEAT_IDX 10'h176
`define TSL_STATUS_IDX 10'h177
// Control register fields
`define TSL_CTRL_ABORT 7
`define TSL_CTRL_MF_HI 6
`define TSL_CTRL_MF_LO 5
`define TSL_CTRL_RXEN 4
`define TSL_CTRL_RESET 3
`define TSL_CTRL_VF_HI 2
`define TSL_CTRL_VF_LO 1
`define TSL_CTRL_SEND 0
// Status register fields; alarm bits write one to clear, busy is read only
`define TSL_ST_CHANGE 0
`define TSL_ST_MATCH_LO 1
`define TSL_ST_BUSY 4
// Reset values
`define TSL_CTRL_RST 8'h00
`define TSL_CODE_RST 6'h00
`define TSL_REPEAT_RST 8'h01
// Line patterns
`define TSL_FLAG_BYTE 8'h7e
`define TSL_ABORT_BYTE 8'hff
`define TSL_PAT_ONES 8'hff
`define TSL_MSG_LAST 4'hf
`define TSL_BYTE_LAST 4'h7
// Filter thresholds
`define TSL_THR_NONE 3'h1
`define TSL_THR_01 3'h3
`define TSL_THR_10 3'h5
`define TSL_THR_11 3'h7
`endif

// *** design/tsl_code_filter.v ***
`timescale 1ns/100ps
`include "tsl_defs.vh"
module tsl_code_filter (
  input wire pclk,
  input wire presetn,
  input wire clr,
  input wire pat_stb,
  input wire pat_ok,
  input wire [5:0] pat_code,
  input wire [1:0] sel,
  output reg qual_q,
  output reg [5:0] qual_code_q
);
  reg [5:0] last_q;
  reg [2:0] cnt_q;
  reg have_q;
  reg [2:0] thr;
  reg [2:0] cnt_d;
  reg same;

  always @* begin
    case (sel)
      2'b00: thr = `TSL_THR_NONE;
      2'b01: thr = `TSL_THR_01;
      2'b10: thr = `TSL_THR_10;
      default: thr = `TSL_THR_11;
    endcase
    same = have_q && (pat_code == last_q);
    if (!same) begin
      cnt_d = 3'h1;
    end else if (cnt_q == 3'h7) begin
      cnt_d = cnt_q;
    end else begin
      cnt_d = cnt_q + 3'h1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 6'h00;
      cnt_q <= 3'h0;
      have_q <= 1'b0;
      qual_q <= 1'b0;
      qual_code_q <= 6'h00;
    end else if (clr) begin
      last_q <= 6'h00;
      cnt_q <= 3'h0;
      have_q <= 1'b0;
      qual_q <= 1'b0;
      qual_code_q <= 6'h00;
    end else begin
      qual_q <= 1'b0;
      if (pat_stb) begin
        if (!pat_ok) begin
          cnt_q <= 3'h0; // [RULE18]
          have_q <= 1'b0;
        end else begin
          cnt_q <= cnt_d; // [RULE18]
          last_q <= pat_code;
          have_q <= 1'b1;
          // Fires once per run, at the point the count is reached; with sel 00 on every clean pattern
          if (sel == 2'b00 || (cnt_d == thr && cnt_q != thr)) begin
            qual_q <= 1'b1;
            qual_code_q <= pat_code;
          end
        end
      end
    end
  end
endmodule

// *** design/tsl_top.v ***
// Our own choice: the APB slave port.
`timescale 1ns/100ps
`include "tsl_defs.vh"
// How it works
// RULE1 - Each code goes out least significant bit first on the data link.
// RULE2 - Pattern is 0, six code bits, 0, then eight ones.
// RULE3 - After a message send idle flag, or abort when abort bit set.
// RULE4 - Match filter needs 0, 3, 5 or 7 clean identical patterns.
// RULE5 - Receiver disabled when enable is 0; codes only from data link.
// RULE6 - Pattern reporting continues whether or not receiver is enabled.
// RULE7 - Controller reset restores defaults except alarms, then clears itself.
// RULE8 - Valid filter needs 0, 3, 5 or 7 patterns before store and alarm.
// RULE9 - Send bit starts transmission of stored code and clears itself.
// RULE10 - Message inserted into data link slots then abort or idle follows.
// RULE11 - Received code field holds last code passing the valid filter.
// RULE12 - Three expected codes compared, each with its own alarm.
// RULE13 - One match filter shared by all three comparisons; two filters total.
// RULE14 - Repeat count defaults to 1; zero means continuous sending.
// RULE15 - Software stops continuous sending with nonzero count and new send.
// RULE16 - Receiver offers change alarm plus three independent match alarms.
// RULE17 - Software writes transmit code before triggering send.
// RULE18 - Filter count restarts on a different or errored pattern.
// RULE19 - Change alarm when newly qualified code differs from stored code.
module tsl_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire fdl_tx_req,
  output reg fdl_tx_bit_q,
  input wire fdl_rx_stb,
  input wire fdl_rx_bit,
  input wire fdl_rx_err,
  output reg code_pattern_seen_q,
  output reg change_alarm_q,
  output reg [2:0] match_alarm_q
);
  localparam S_IDLE = 2'd0;
  localparam S_MSG = 2'd1;
  localparam S_TAIL = 2'd2;

  reg abort_after_message_q;
  reg [1:0] match_filter_select_q;
  reg code_receiver_enable_q;
  reg [1:0] valid_filter_select_q;
  reg [5:0] received_code_field_q;
  reg [5:0] exp_q [0:2];
  reg [5:0] outgoing_code_field_q;
  reg [7:0] repeat_count_field_q;
  reg soft_rst_q;
  reg send_pend_q;
  reg [1:0] tx_state_q;
  reg [3:0] tx_idx_q;
  reg [15:0] tx_word_q;
  reg [7:0] tx_left_q;
  reg tx_cont_q;
  reg [15:0] rx_sr_q;
  reg [15:0] rx_err_q;
  reg have_code_q;

  wire wr_en = psel && penable && pready && pwrite;
  wire [9:0] idx = paddr[11:2];
  wire aligned = (paddr[1:0] == 2'b00);
  wire ctrl_wr = wr_en && aligned && idx == `TSL_CTRL_IDX;
  wire st_wr = wr_en && aligned && idx == `TSL_STATUS_IDX;
  wire send_go = ctrl_wr && pwdata[`TSL_CTRL_SEND]; // [RULE9]
  wire rst_go = ctrl_wr && pwdata[`TSL_CTRL_RESET]; // [RULE7]

  // Receive pattern shaping: ones arrive first, then 0, code, 0
  wire pat_shape = rx_sr_q[7:0] == `TSL_PAT_ONES && !rx_sr_q[8] && !rx_sr_q[15]; // [RULE2]
  reg pat_stb_q;
  reg pat_ok_q;
  reg [5:0] pat_code_q;
  wire filt_clr = soft_rst_q || !code_receiver_enable_q; // [RULE5]
  wire vq;
  wire [5:0] vcode;
  wire mq;
  wire [5:0] mcode;
  wire busy = tx_state_q != S_IDLE || send_pend_q;

  // The valid-code filter
  tsl_code_filter u_valid (
    .pclk(pclk),
    .presetn(presetn),
    .clr(filt_clr),
    .pat_stb(pat_stb_q),
    .pat_ok(pat_ok_q),
    .pat_code(pat_code_q),
    .sel(valid_filter_select_q), // [RULE8]
    .qual_q(vq),
    .qual_code_q(vcode)
  );

  // The shared match filter, one for all three comparisons
  tsl_code_filter u_match (
    .pclk(pclk),
    .presetn(presetn),
    .clr(filt_clr),
    .pat_stb(pat_stb_q),
    .pat_ok(pat_ok_q),
    .pat_code(pat_code_q),
    .sel(match_filter_select_q), // [RULE4] [RULE13]
    .qual_q(mq),
    .qual_code_q(mcode)
  );

  // APB: pready rises in the access phase, data prepared in setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        if (!aligned) begin
          pslverr <= 1'b1;
        end else begin
          case (idx)
            `TSL_CTRL_IDX: prdata <= {24'h000000, abort_after_message_q, match_filter_select_q,
              code_receiver_enable_q, 1'b0, valid_filter_select_q, 1'b0};
            `TSL_RXCODE_IDX: prdata <= {26'h0000000, received_code_field_q}; // [RULE11]
            `TSL_EXP1_IDX: prdata <= {26'h0000000, exp_q[0]};
            `TSL_EXP2_IDX: prdata <= {26'h0000000, exp_q[1]};
            `TSL_EXP3_IDX: prdata <= {26'h0000000, exp_q[2]};
            `TSL_TXCODE_IDX: prdata <= {26'h0000000, outgoing_code_field_q};
            `TSL_REPEAT_IDX: prdata <= {24'h000000, repeat_count_field_q};
            `TSL_STATUS_IDX: prdata <= {27'h0000000, busy, match_alarm_q, change_alarm_q};
            default: pslverr <= 1'b1;
          endcase
        end
      end
    end
  end

  // Register file; soft reset leaves the alarm flags alone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_after_message_q <= 1'b0;
      match_filter_select_q <= 2'b00;
      code_receiver_enable_q <= 1'b0;
      valid_filter_select_q <= 2'b00;
      exp_q[0] <= `TSL_CODE_RST;
      exp_q[1] <= `TSL_CODE_RST;
      exp_q[2] <= `TSL_CODE_RST;
      outgoing_code_field_q <= `TSL_CODE_RST;
      repeat_count_field_q <= `TSL_REPEAT_RST;
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= rst_go; // [RULE7]
      if (soft_rst_q) begin
        abort_after_message_q <= 1'b0; // [RULE7]
        match_filter_select_q <= 2'b00;
        code_receiver_enable_q <= 1'b0;
        valid_filter_select_q <= 2'b00;
        exp_q[0] <= `TSL_CODE_RST;
        exp_q[1] <= `TSL_CODE_RST;
        exp_q[2] <= `TSL_CODE_RST;
        outgoing_code_field_q <= `TSL_CODE_RST;
        repeat_count_field_q <= `TSL_REPEAT_RST;
      end else if (wr_en && aligned) begin
        case (idx)
          `TSL_CTRL_IDX: begin
            abort_after_message_q <= pwdata[`TSL_CTRL_ABORT];
            match_filter_select_q <= pwdata[`TSL_CTRL_MF_HI:`TSL_CTRL_MF_LO];
            code_receiver_enable_q <= pwdata[`TSL_CTRL_RXEN];
            valid_filter_select_q <= pwdata[`TSL_CTRL_VF_HI:`TSL_CTRL_VF_LO];
          end
          `TSL_EXP1_IDX: exp_q[0] <= pwdata[5:0];
          `TSL_EXP2_IDX: exp_q[1] <= pwdata[5:0];
          `TSL_EXP3_IDX: exp_q[2] <= pwdata[5:0];
          `TSL_TXCODE_IDX: outgoing_code_field_q <= pwdata[5:0]; // [RULE17]
          `TSL_REPEAT_IDX: repeat_count_field_q <= pwdata[7:0];
          default: soft_rst_q <= rst_go;
        endcase
      end
    end
  end

  // Transmitter, advanced one bit per data link slot request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_pend_q <= 1'b0;
      tx_state_q <= S_IDLE;
      tx_idx_q <= 4'h0;
      tx_word_q <= {8'h00, `TSL_FLAG_BYTE};
      tx_left_q <= 8'h00;
      tx_cont_q <= 1'b0;
      fdl_tx_bit_q <= 1'b0;
    end else if (soft_rst_q) begin
      send_pend_q <= 1'b0;
      tx_state_q <= S_IDLE;
      tx_idx_q <= 4'h0;
      tx_word_q <= {8'h00, `TSL_FLAG_BYTE};
      tx_left_q <= 8'h00;
      tx_cont_q <= 1'b0;
    end else begin
      // A trigger landing on the consuming slot is kept, not lost
      if (send_go) begin
        send_pend_q <= 1'b1; // [RULE9]
      end
      if (fdl_tx_req) begin
        fdl_tx_bit_q <= tx_word_q[tx_idx_q]; // [RULE1] [RULE10]
        tx_idx_q <= tx_idx_q + 4'h1;
        case (tx_state_q)
          S_MSG: begin
            if (tx_idx_q == `TSL_MSG_LAST) begin
              // New send while busy reloads code and count
              if (send_pend_q) begin
                send_pend_q <= send_go;
                tx_word_q <= {1'b0, outgoing_code_field_q, 1'b0, `TSL_PAT_ONES}; // [RULE2]
                tx_left_q <= repeat_count_field_q; // [RULE15]
                tx_cont_q <= repeat_count_field_q == 8'h00;
              end else if (!tx_cont_q && tx_left_q <= 8'h01) begin
                tx_state_q <= S_TAIL; // [RULE14]
                tx_word_q <= {8'h00, abort_after_message_q ? `TSL_ABORT_BYTE
                  : `TSL_FLAG_BYTE}; // [RULE3]
              end else if (!tx_cont_q) begin
                tx_left_q <= tx_left_q - 8'h01; // [RULE14]
              end
            end
          end
          default: begin
            if (tx_idx_q == `TSL_BYTE_LAST) begin
              tx_idx_q <= 4'h0;
              if (send_pend_q) begin
                send_pend_q <= send_go;
                tx_state_q <= S_MSG;
                tx_word_q <= {1'b0, outgoing_code_field_q, 1'b0, `TSL_PAT_ONES}; // [RULE2]
                tx_left_q <= repeat_count_field_q;
                tx_cont_q <= repeat_count_field_q == 8'h00; // [RULE14]
              end else begin
                tx_state_q <= S_IDLE;
                tx_word_q <= {8'h00, `TSL_FLAG_BYTE}; // [RULE3]
              end
            end
          end
        endcase
      end
    end
  end

  // Receive shifter; codes come only from the data link bit stream
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sr_q <= 16'h0000;
      rx_err_q <= 16'h0000;
      pat_stb_q <= 1'b0;
      pat_ok_q <= 1'b0;
      pat_code_q <= 6'h00;
      code_pattern_seen_q <= 1'b0;
    end else begin
      pat_stb_q <= 1'b0;
      code_pattern_seen_q <= 1'b0;
      if (fdl_rx_stb) begin
        rx_sr_q <= {fdl_rx_bit, rx_sr_q[15:1]}; // [RULE5]
        rx_err_q <= {fdl_rx_err, rx_err_q[15:1]};
      end
      if (pat_shape && !pat_stb_q && !code_pattern_seen_q && rx_err_q != 16'hffff) begin
        code_pattern_seen_q <= 1'b0;
      end
      if (fdl_rx_stb && pat_shape_next(1'b0)) begin
        pat_stb_q <= code_receiver_enable_q; // [RULE5]
        pat_ok_q <= ({fdl_rx_err, rx_err_q[15:1]} == 16'h0000);
        pat_code_q <= rx_sr_q[15:10];
        code_pattern_seen_q <= 1'b1; // [RULE6]
      end
    end
  end

  // Shape test on the word as it will stand after this bit
  function pat_shape_next;
    input dummy;
    reg [15:0] w;
    begin
      w = {fdl_rx_bit, rx_sr_q[15:1]};
      pat_shape_next = w[7:0] == `TSL_PAT_ONES && !w[8] && !w[15];
    end
  endfunction

  // Valid code store, change alarm and match alarms; set wins over clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      received_code_field_q <= `TSL_CODE_RST;
      have_code_q <= 1'b0;
      change_alarm_q <= 1'b0;
    end else begin
      if (st_wr && pwdata[`TSL_ST_CHANGE]) begin
        change_alarm_q <= 1'b0;
      end
      if (soft_rst_q) begin
        received_code_field_q <= `TSL_CODE_RST;
        have_code_q <= 1'b0;
      end else if (vq) begin
        received_code_field_q <= vcode; // [RULE11] [RULE8]
        have_code_q <= 1'b1;
        if (have_code_q && vcode != received_code_field_q) begin
          change_alarm_q <= 1'b1; // [RULE19] [RULE16]
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_match
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          match_alarm_q[g] <= 1'b0;
        end else if (mq && mcode == exp_q[g]) begin
          match_alarm_q[g] <= 1'b1; // [RULE12] [RULE16]
        end else if (st_wr && pwdata[`TSL_ST_MATCH_LO + g]) begin
          match_alarm_q[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

// *** bench/tsl_top_asserts.sv ***
`timescale 1ns/100ps
module tsl_top_asserts (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire fdl_tx_req,
  input wire fdl_tx_bit_q,
  input wire fdl_rx_stb,
  input wire code_pattern_seen_q,
  input wire change_alarm_q,
  input wire [2:0] match_alarm_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire wr_acc = acc && pwrite;
  property p_ready_in_access; acc |-> pready; endproperty
  a_ready_in_access: assert property (p_ready_in_access) else $error("no ready in access");
  property p_ready_only_access; !acc |-> !pready; endproperty
  a_ready_only_access: assert property (p_ready_only_access) else $error("stray ready");
  property p_err_with_ready; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("bad error answer");
  property p_seen_pulse;
    code_pattern_seen_q |-> $past(fdl_rx_stb) ##1 !code_pattern_seen_q;
  endproperty
  a_seen_pulse: assert property (p_seen_pulse) else $error("seen pulse wrong");
  property p_change_sticky; change_alarm_q && !wr_acc |=> change_alarm_q; endproperty
  a_change_sticky: assert property (p_change_sticky) else $error("change lost");
  property p_match_sticky;
    !wr_acc |=> (match_alarm_q & $past(match_alarm_q)) == $past(match_alarm_q);
  endproperty
  a_match_sticky: assert property (p_match_sticky) else $error("match lost");
  property p_change_cause; $rose(change_alarm_q) |-> $past(code_pattern_seen_q, 2); endproperty
  a_change_cause: assert property (p_change_cause) else $error("change uncaused");
  property p_match_cause;
    |(match_alarm_q & ~$past(match_alarm_q)) |-> $past(code_pattern_seen_q, 2);
  endproperty
  a_match_cause: assert property (p_match_cause) else $error("match uncaused");
  property p_tx_hold; !$past(fdl_tx_req) |-> $stable(fdl_tx_bit_q); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx bit moved");
  c_match: cover property (match_alarm_q[0]);
  c_change: cover property (change_alarm_q);
  c_refuse: cover property (acc && pslverr);
endmodule
bind tsl_top tsl_top_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .fdl_tx_req, .fdl_tx_bit_q, .fdl_rx_stb, .code_pattern_seen_q,
  .change_alarm_q, .match_alarm_q);

// *** bench/tsl_far_end.sv ***
`timescale 1ns/100ps
module tsl_far_end (
  input wire pclk,
  input wire presetn,
  output reg tx_req,
  input wire tx_bit,
  output reg rx_stb,
  output reg rx_bit,
  output reg rx_err
);
  reg [47:0] hist;
  reg [1:0] slot_q;
  initial begin
    rx_stb = 1'b0;
    rx_bit = 1'b1;
    rx_err = 1'b0;
  end
  // Slots come once every four pclk cycles, slower than pclk, as link bits do in a frame
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_q <= 2'h0;
      tx_req <= 1'b0;
      hist <= 48'h0;
    end else begin
      slot_q <= slot_q + 2'h1;
      tx_req <= (slot_q == 2'h3);
      if (tx_req) begin
        hist <= {tx_bit, hist[47:1]};
      end
    end
  end
  task send(input [5:0] code, input bad);
    reg [15:0] w;
    integer i;
    begin
      w = {1'b0, code, 1'b0, 8'hff};
      for (i = 0; i < 16; i = i + 1) begin
        @(posedge pclk);
        rx_stb <= 1'b1;
        rx_bit <= w[i];
        rx_err <= bad && (i == 4);
        @(posedge pclk);
        rx_stb <= 1'b0;
        rx_bit <= ~w[i];
        rx_err <= 1'b0;
      end
      repeat (4) @(posedge pclk);
    end
  endtask
endmodule

// *** bench/tsl_top_test.sv ***
`timescale 1ns/100ps
`include "tsl_defs.vh"
module tsl_top_test;
  reg pclk, presetn, psel, penable, pwrite, err;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg [7:0] lfsr;
  reg [5:0] ca, cb, cx, prev;
  wire [31:0] prdata;
  wire pready, pslverr, tx_req, tx_bit, rx_stb, rx_bit, rx_err, seen, chg;
  wire [2:0] mat;
  integer bad_count, total_checks, seen_n, i;
  tsl_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fdl_tx_req(tx_req), .fdl_tx_bit_q(tx_bit), .fdl_rx_stb(rx_stb),
    .fdl_rx_bit(rx_bit), .fdl_rx_err(rx_err), .code_pattern_seen_q(seen),
    .change_alarm_q(chg), .match_alarm_q(mat));
  tsl_far_end i_far (.pclk(pclk), .presetn(presetn), .tx_req(tx_req), .tx_bit(tx_bit),
    .rx_stb(rx_stb), .rx_bit(rx_bit), .rx_err(rx_err));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) if (seen === 1'b1) seen_n = seen_n + 1;
  function [7:0] nxt(input [7:0] v);
    nxt = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function [3:0] thr(input [1:0] s);
    thr = {1'b0, s, 1'b1};
  endfunction
  function [15:0] wd(input [5:0] c);
    wd = {1'b0, c, 1'b0, 8'hff};
  endfunction
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task apb(input wr, input [9:0] idx, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Answer is read mid-cycle; it stands unchanged up to the sampling edge
      @(negedge pclk);
      while (pready !== 1'b1) begin
        @(posedge pclk);
        @(negedge pclk);
      end
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
    end
  endtask
  task rd_chk(input string nm, input [9:0] idx, input [31:0] exp);
    begin
      apb(1'b0, idx, 32'h0);
      chk(nm, rd, exp);
    end
  endtask
  task burst(input [5:0] c, input [3:0] n);
    repeat (n) i_far.send(c, 1'b0);
  endtask
  task tx_wait(input string nm, input [47:0] pat, input [47:0] msk);
    integer n;
    begin
      n = 0;
      while ((i_far.hist & msk) !== pat && n < 4000) begin
        n = n + 1;
        @(posedge pclk);
      end
      chk(nm, n < 4000, 1);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count = bad_count + 1;
    final_report;
  end
  initial begin
    bad_count = 0;
    total_checks = 0;
    seen_n = 0;
    lfsr = 8'h4c;
    prev = 6'h00;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      rd_chk("reset", `TSL_CTRL_IDX + i[9:0], (i == 6) ? 32'h1 : 32'h0);
    end
    apb(1'b0, 10'h17f, 32'h0);
    chk("unmapped", err, 1);
    lfsr = nxt(lfsr);
    ca = {lfsr[5:2], 2'b10};
    cb = ~ca;
    apb(1'b1, `TSL_EXP1_IDX, {26'h0, ca});
    apb(1'b1, `TSL_EXP2_IDX, {26'h0, ca});
    apb(1'b1, `TSL_EXP3_IDX, {26'h0, cb});
    rd_chk("exp3", `TSL_EXP3_IDX, {26'h0, cb});
    // Codes alternate so every qualification after the first is also a change of status
    for (i = 0; i < 4; i = i + 1) begin
      cx = i[0] ? ca : cb;
      apb(1'b1, `TSL_CTRL_IDX, {24'h0, 1'b0, i[1:0], 2'b10, i[1:0], 1'b0});
      apb(1'b1, `TSL_STATUS_IDX, 32'h0f);
      chk("clear", {chg, mat}, 0);
      burst(cx, thr(i[1:0]) - 4'h1);
      i_far.send(cx, 1'b1);
      burst(cx, thr(i[1:0]) - 4'h1);
      rd_chk("short run", `TSL_RXCODE_IDX, {26'h0, prev});
      chk("no match", mat, 0);
      burst(cx, 4'h1);
      rd_chk("qualified", `TSL_RXCODE_IDX, {26'h0, cx});
      chk("match", mat, {cx == cb, cx == ca, cx == ca});
      chk("change", chg, i > 0);
      prev = cx;
    end
    apb(1'b1, `TSL_CTRL_IDX, 32'h08);
    repeat (2) @(posedge pclk);
    rd_chk("soft ctrl", `TSL_CTRL_IDX, 0);
    rd_chk("soft code", `TSL_RXCODE_IDX, 0);
    rd_chk("soft exp", `TSL_EXP1_IDX, 0);
    chk("kept alarm", chg, 1);
    apb(1'b1, `TSL_STATUS_IDX, 32'h0f);
    seen_n = 0;
    burst(cb, 4'h3);
    rd_chk("disabled", `TSL_RXCODE_IDX, 0);
    chk("seen count", seen_n, 3);
    lfsr = nxt(lfsr);
    cx = lfsr[5:0] & 6'h3e;
    apb(1'b1, `TSL_TXCODE_IDX, {26'h0, cx});
    apb(1'b1, `TSL_REPEAT_IDX, 32'h2);
    apb(1'b1, `TSL_CTRL_IDX, 32'h81);
    rd_chk("send clears", `TSL_CTRL_IDX, 32'h80);
    tx_wait("abort tail", {8'h0, 8'hff, wd(cx), wd(cx)}, 48'hff_ffff_ffff);
    apb(1'b1, `TSL_REPEAT_IDX, 32'h1);
    apb(1'b1, `TSL_CTRL_IDX, 32'h01);
    tx_wait("idle tail", {24'h0, 8'h7e, wd(cx)}, 48'hff_ffff);
    apb(1'b1, `TSL_REPEAT_IDX, 32'h0);
    apb(1'b1, `TSL_CTRL_IDX, 32'h01);
    tx_wait("continuous", {wd(cx), wd(cx), wd(cx)}, {48{1'b1}});
    apb(1'b1, `TSL_REPEAT_IDX, 32'h1);
    apb(1'b1, `TSL_CTRL_IDX, 32'h81);
    tx_wait("stopped", {16'h0, 8'h7e, 8'hff, wd(cx)}, 48'hffff_ffff);
    final_report;
  end
endmodule
